/* hw/dss_pkg.sv */
/*
  Constants and state type shared by the start/stop sequencer.
  Assumes one 40 MHz system clock; speeds are 12-bit magnitudes, times are in ms.
*/
package dss_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int SPEED_W = 12;
  localparam int TIME_W = 16;
  localparam logic [SPEED_W-1:0] SPEED_FULL = 12'hfff;
  localparam logic [SPEED_W-1:0] SPEED_ZERO = 12'h000;
  // Final stop time default, 10.0 s
  localparam int STOP_TIME_DEF_S = 10;
  localparam logic [TIME_W-1:0] STOP_TIME_DEF_MS = TIME_W'(STOP_TIME_DEF_S * MS_PER_S);
  // Stop input must be low longer than this to count
  localparam int STOP_MIN_MS = 100;
  localparam logic [7:0] STOP_MIN_TICKS = 8'(STOP_MIN_MS + 1);
  // Stop mode encodings; zero is ramp so a tied-off port gives the default
  localparam logic STOP_RAMP = 1'b0;
  localparam logic STOP_COAST = 1'b1;
  // Pin vector positions
  localparam int P_KRUN = 0;
  localparam int P_KSTOP = 1;
  localparam int P_KINCH = 2;
  localparam int P_KDIR = 3;
  localparam int P_RFWD = 4;
  localparam int P_RREV = 5;
  localparam int P_RINCH = 6;
  localparam int P_STOPN = 7;
  localparam int P_FASTN = 8;
  localparam int P_COASTN = 9;
  localparam int P_PERMIT = 10;
  localparam int P_TRIP = 11;
  localparam int P_TRST = 12;
  localparam int NPIN = 13;
  localparam logic [NPIN-1:0] PIN_RST = 13'h0000;
  typedef enum logic [2:0] {IDLE, RUN, INCH, DECEL, TRIMDOWN, STOPDELAY} dss_state_t;
endpackage

/* hw/dss_sequencer.sv */
/*
  Start/stop sequencer: turns keypad and remote start/stop pins into a ramped
  speed command, power-stack enable and status. Pins are asynchronous and are
  filtered here; references, times and modes come from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer #(
  parameter int CYC_MS = dss_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Source selection
  input wire logic seqRemote,
  input wire logic refRemote,
  // Keypad keys (pins)
  input wire logic keyRun,
  input wire logic keyStop,
  input wire logic keyInch,
  input wire logic keyDir,
  // Remote inputs (pins)
  input wire logic remRunFwd,
  input wire logic remRunRev,
  input wire logic remInch,
  input wire logic remStopN,
  input wire logic fastStopN,
  input wire logic coastStopN,
  input wire logic driveEnable,
  input wire logic tripActive,
  input wire logic tripReset,
  // References and ramp settings
  input wire logic [dss_pkg::SPEED_W-1:0] remoteReference,
  input wire logic [dss_pkg::SPEED_W-1:0] keypadReference,
  input wire logic [dss_pkg::SPEED_W-1:0] inchTarget,
  input wire logic [dss_pkg::SPEED_W-1:0] trimValue,
  input wire logic trimEnable,
  input wire logic rampHold,
  input wire logic [dss_pkg::TIME_W-1:0] rampupTime,
  input wire logic [dss_pkg::TIME_W-1:0] rampdownTime,
  input wire logic [dss_pkg::TIME_W-1:0] inchRampTime,
  input wire logic [dss_pkg::TIME_W-1:0] finalStopTime,
  input wire logic [dss_pkg::TIME_W-1:0] fastStopTime,
  input wire logic [dss_pkg::TIME_W-1:0] stopDelay,
  input wire logic runStopMode,
  input wire logic fastStopMode,
  // Status and drive outputs
  output logic [dss_pkg::SPEED_W-1:0] speedCommand,
  output logic remoteDirOut,
  output logic stackEnable,
  output logic active,
  output logic noFaultFlag
);
  import dss_pkg::*;

  function automatic logic [SPEED_W-1:0] moveToward(input logic [SPEED_W-1:0] cur,
                                                    input logic [SPEED_W-1:0] tgt, input logic step);
    moveToward = cur;
    if (step && cur < tgt) begin
      moveToward = cur + 12'h001;
    end else if (step && cur > tgt) begin
      moveToward = cur - 12'h001;
    end
  endfunction

  // Pin filter: three flops, change taken when second and third agree
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] syncA_reg, syncB_reg, syncC_reg, pinStable_reg, pinPrev_reg;
  logic [NPIN-1:0] pinStable_next;
  assign pinRaw = {tripReset, tripActive, driveEnable, coastStopN, fastStopN, remStopN, remInch,
                   remRunRev, remRunFwd, keyDir, keyInch, keyStop, keyRun};
  always_comb begin
    pinStable_next = pinStable_reg;
    for (int i = 0; i < NPIN; i++) begin
      if (syncB_reg[i] == syncC_reg[i]) begin
        pinStable_next[i] = syncC_reg[i];
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncA_reg <= PIN_RST;
      syncB_reg <= PIN_RST;
      syncC_reg <= PIN_RST;
      pinStable_reg <= PIN_RST;
      pinPrev_reg <= PIN_RST;
    end else begin
      syncA_reg <= pinRaw;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      pinStable_reg <= pinStable_next;
      pinPrev_reg <= pinStable_reg;
    end
  end

  logic kRunRise, kDirRise, fwdOnly, revOnly, stopLow, fastLow, coastLow, permit, trRise;
  assign kRunRise = pinStable_reg[P_KRUN] & ~pinPrev_reg[P_KRUN];
  assign kDirRise = pinStable_reg[P_KDIR] & ~pinPrev_reg[P_KDIR];
  assign trRise = pinStable_reg[P_TRST] & ~pinPrev_reg[P_TRST];
  assign fwdOnly = pinStable_reg[P_RFWD] & ~pinStable_reg[P_RREV];
  assign revOnly = pinStable_reg[P_RREV] & ~pinStable_reg[P_RFWD];
  assign stopLow = ~pinStable_reg[P_STOPN];
  assign coastLow = ~pinStable_reg[P_COASTN];
  assign fastLow = ~pinStable_reg[P_FASTN] & ~coastLow;
  assign permit = pinStable_reg[P_PERMIT];

  // Millisecond tick; long counts live here so the stop and delay counters stay 8 and 16 bits; ramps do not use it
  logic [31:0] msCnt_reg, msCnt_next;
  logic msTick;
  assign msTick = (msCnt_reg == 32'(CYC_MS - 1));
  always_comb begin
    msCnt_next = msTick ? 32'h0000_0000 : msCnt_reg + 32'h0000_0001;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      msCnt_reg <= 32'h0000_0000;
    end else begin
      msCnt_reg <= msCnt_next;
    end
  end

  // Start latching: remote three-wire, keypad run/stop, trip latch
  logic [7:0] stopLowCnt_reg, stopLowCnt_next;
  logic remLatch_reg, remLatch_next, remLatchRev_reg, remLatchRev_next;
  logic locLatch_reg, locLatch_next, locRev_reg, locRev_next;
  logic tripLat_reg, tripLat_next;
  logic stopQual, runReq, inchReq, reqRev;
  assign stopQual = (stopLowCnt_reg >= STOP_MIN_TICKS);
  always_comb begin
    stopLowCnt_next = stopLowCnt_reg;
    if (!stopLow) begin
      stopLowCnt_next = 8'h00;
    end else if (msTick && !stopQual) begin
      stopLowCnt_next = stopLowCnt_reg + 8'h01;
    end
    remLatch_next = remLatch_reg;
    remLatchRev_next = remLatchRev_reg;
    if (stopQual || (pinStable_reg[P_RFWD] && pinStable_reg[P_RREV])) begin
      remLatch_next = 1'b0;
    end else if (!stopLow && (fwdOnly || revOnly) && !pinStable_reg[P_RINCH]) begin
      remLatch_next = 1'b1;
      remLatchRev_next = revOnly;
    end
    locLatch_next = locLatch_reg;
    if (pinStable_reg[P_KSTOP]) begin
      locLatch_next = 1'b0;
    end else if (kRunRise && !pinStable_reg[P_KINCH]) begin
      locLatch_next = 1'b1;
    end
    locRev_next = kDirRise ? ~locRev_reg : locRev_reg;
    tripLat_next = tripLat_reg;
    if (pinStable_reg[P_TRIP]) begin
      tripLat_next = 1'b1;
    end else if (trRise) begin
      tripLat_next = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stopLowCnt_reg <= 8'h00;
      remLatch_reg <= 1'b0;
      remLatchRev_reg <= 1'b0;
      locLatch_reg <= 1'b0;
      locRev_reg <= 1'b0;
      tripLat_reg <= 1'b0;
    end else begin
      stopLowCnt_reg <= stopLowCnt_next;
      remLatch_reg <= remLatch_next;
      remLatchRev_reg <= remLatchRev_next;
      locLatch_reg <= locLatch_next;
      locRev_reg <= locRev_next;
      tripLat_reg <= tripLat_next;
    end
  end

  // Sequencing source chosen here; reference source chosen independently below
  always_comb begin
    if (seqRemote) begin
      runReq = fwdOnly | revOnly | remLatch_reg;
      reqRev = (fwdOnly | revOnly) ? revOnly : remLatchRev_reg;
      inchReq = pinStable_reg[P_RINCH];
    end else begin
      runReq = locLatch_reg;
      reqRev = locRev_reg;
      inchReq = pinStable_reg[P_KINCH];
    end
  end

  // Sequencer and ramps
  dss_state_t state_reg, state_next;
  logic [SPEED_W-1:0] ramp_reg, ramp_next, trim_reg, trim_next, spd_reg, spd_next;
  logic [31:0] rampAcc_reg, rampAcc_next, trimAcc_reg, trimAcc_next;
  logic [TIME_W-1:0] delayCnt_reg, delayCnt_next, rampTime, finTime;
  logic fastSeq_reg, fastSeq_next, dir_reg, dir_next, stack_reg, stack_next;
  logic act_reg, act_next, nf_reg, nf_next;
  logic [SPEED_W-1:0] rampTgt, refSel;
  logic [31:0] rampLim, trimLim;
  logic rampStep, trimStep, slowStop, stopMode;
  logic [SPEED_W:0] sum;

  always_comb begin
    finTime = (finalStopTime == 16'h0000) ? STOP_TIME_DEF_MS : finalStopTime;
    slowStop = (rampdownTime == 16'h0000) || rampHold;
    refSel = refRemote ? remoteReference : keypadReference;
    rampTgt = SPEED_ZERO;
    rampTime = rampdownTime;
    unique case (state_reg)
      RUN: begin
        rampTgt = refSel;
        rampTime = rampupTime;
      end
      INCH: begin
        rampTgt = inchTarget;
        rampTime = inchRampTime;
      end
      DECEL: begin
        if (fastSeq_reg) begin
          rampTime = fastStopTime;
        end else if (slowStop) begin
          rampTime = finTime;
        end else begin
          rampTime = rampdownTime;
        end
      end
      IDLE, TRIMDOWN, STOPDELAY: begin
        rampTime = rampdownTime;
      end
    endcase
    // Rate accumulator: full scale moves in rampTime ms; zero time steps every cycle
    rampLim = 32'(rampTime) * 32'(CYC_MS);
    trimLim = 32'(finTime) * 32'(CYC_MS);
    rampAcc_next = rampAcc_reg + 32'(SPEED_FULL);
    rampStep = (rampAcc_next >= rampLim);
    if (rampStep) begin
      rampAcc_next = rampAcc_next - rampLim;
    end
    trimAcc_next = trimAcc_reg + 32'(SPEED_FULL);
    trimStep = (trimAcc_next >= trimLim);
    if (trimStep) begin
      trimAcc_next = trimAcc_next - trimLim;
    end

    state_next = state_reg;
    ramp_next = moveToward(ramp_reg, rampTgt, rampStep && !(state_reg == RUN && rampHold));
    trim_next = trim_reg;
    delayCnt_next = delayCnt_reg;
    fastSeq_next = fastSeq_reg;
    dir_next = dir_reg;
    stopMode = fastLow ? fastStopMode : runStopMode;
    unique case (state_reg)
      IDLE: begin
        ramp_next = SPEED_ZERO;
        trim_next = SPEED_ZERO;
        fastSeq_next = 1'b0;
        // Run wins if both arrive together; the other waits for the next stop
        if (!fastLow && !tripLat_reg && runReq) begin
          state_next = RUN;
          dir_next = reqRev;
        end else if (!fastLow && !tripLat_reg && inchReq) begin
          state_next = INCH;
          dir_next = reqRev;
        end
      end
      RUN, INCH: begin
        trim_next = (state_reg == RUN && trimEnable) ? trimValue : SPEED_ZERO;
        if (state_reg == RUN && runReq) begin
          dir_next = reqRev;
        end
        // Inch ignored while running and run ignored while inching
        if (fastLow || (state_reg == RUN ? !runReq : !inchReq)) begin
          fastSeq_next = fastLow;
          if (stopMode == STOP_COAST) begin
            state_next = IDLE;
            ramp_next = SPEED_ZERO;
            trim_next = SPEED_ZERO;
          end else begin
            state_next = DECEL;
          end
        end
      end
      DECEL: begin
        // Once begun, run inputs returning high do not cancel the stop
        if (slowStop && !fastSeq_reg) begin
          trim_next = moveToward(trim_reg, SPEED_ZERO, rampStep);
        end
        if (ramp_reg == SPEED_ZERO) begin
          state_next = TRIMDOWN;
        end
      end
      TRIMDOWN: begin
        trim_next = moveToward(trim_reg, SPEED_ZERO, trimStep);
        delayCnt_next = 16'h0000;
        if (trim_reg == SPEED_ZERO) begin
          state_next = STOPDELAY;
        end
      end
      STOPDELAY: begin
        if (delayCnt_reg >= stopDelay) begin
          state_next = IDLE;
        end else if (msTick) begin
          delayCnt_next = delayCnt_reg + 16'h0001;
        end
      end
    endcase
    // Coast input and trip cut everything from any state
    if (coastLow || tripLat_reg || pinStable_reg[P_TRIP]) begin
      state_next = IDLE;
      ramp_next = SPEED_ZERO;
      trim_next = SPEED_ZERO;
    end
    sum = {1'b0, ramp_next} + {1'b0, trim_next};
    spd_next = sum[SPEED_W] ? SPEED_FULL : sum[SPEED_W-1:0];
    stack_next = (state_next != IDLE) && permit;
    act_next = (state_next != IDLE);
    nf_next = !tripLat_next;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= IDLE;
      ramp_reg <= SPEED_ZERO;
      trim_reg <= SPEED_ZERO;
      spd_reg <= SPEED_ZERO;
      rampAcc_reg <= 32'h0000_0000;
      trimAcc_reg <= 32'h0000_0000;
      delayCnt_reg <= 16'h0000;
      fastSeq_reg <= 1'b0;
      dir_reg <= 1'b0;
      stack_reg <= 1'b0;
      act_reg <= 1'b0;
      nf_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ramp_reg <= ramp_next;
      trim_reg <= trim_next;
      spd_reg <= spd_next;
      rampAcc_reg <= rampAcc_next;
      trimAcc_reg <= trimAcc_next;
      delayCnt_reg <= delayCnt_next;
      fastSeq_reg <= fastSeq_next;
      dir_reg <= dir_next;
      stack_reg <= stack_next;
      act_reg <= act_next;
      nf_reg <= nf_next;
    end
  end

  assign speedCommand = spd_reg;
  assign remoteDirOut = dir_reg;
  assign stackEnable = stack_reg;
  assign active = act_reg;
  assign noFaultFlag = nf_reg;
endmodule
`default_nettype wire

/* verif/dss_operator_model.sv */
/*
  Operator model: keypad keys and remote switches feeding the sequencer pins.
  Assumes requests change just after a clock edge; stop taps get stretched.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_operator_model #(
  parameter int HOLD_CYC = 1100
) (
  // Clock
  input wire logic clk_sys,
  // Requested and driven pin levels
  input wire logic [dss_pkg::NPIN-1:0] pinReq,
  output logic [dss_pkg::NPIN-1:0] pinOut
);
  import dss_pkg::*;
  int holdCnt = 0;
  // A short stop tap would be filtered out, so an operator holds it
  always @(posedge clk_sys) begin
    if (!pinReq[P_STOPN]) begin
      holdCnt <= HOLD_CYC;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end
  end
  always_comb begin
    pinOut = pinReq;
    pinOut[P_STOPN] = pinReq[P_STOPN] && holdCnt == 0;
  end
endmodule
`default_nettype wire

/* verif/dss_sequencer_properties.sv */
/*
  Port assertions for the start/stop sequencer.
  Assumes a pin steady for 8 cycles is past the input filter.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched inputs
  input wire logic seqRemote,
  input wire logic remRunFwd,
  input wire logic remRunRev,
  input wire logic fastStopN,
  input wire logic coastStopN,
  input wire logic driveEnable,
  input wire logic tripActive,
  input wire logic tripReset,
  input wire logic trimEnable,
  input wire logic fastStopMode,
  input wire logic [dss_pkg::TIME_W-1:0] rampupTime,
  input wire logic [dss_pkg::TIME_W-1:0] inchRampTime,
  // Watched outputs
  input wire logic [dss_pkg::SPEED_W-1:0] speedCommand,
  input wire logic stackEnable,
  input wire logic active,
  input wire logic noFaultFlag
);
  import dss_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_permit;
    !driveEnable [*8] |-> !stackEnable;
  endproperty
  a_permit: assert property (p_permit) else $error("stack on without permit");
  property p_coast;
    !coastStopN [*8] |-> !stackEnable && speedCommand == SPEED_ZERO;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop ignored");
  property p_trip;
    tripActive [*8] |-> !noFaultFlag && !stackEnable;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not honoured");
  property p_idle;
    !active |-> !stackEnable && speedCommand == SPEED_ZERO;
  endproperty
  a_idle: assert property (p_idle) else $error("output live while idle");
  property p_latch;
    !tripReset [*8] ##1 !noFaultFlag |=> !noFaultFlag;
  endproperty
  a_latch: assert property (p_latch) else $error("fault cleared without reset");
  property p_step;
    active && $past(active) && rampupTime == 16'h0000 && inchRampTime == 16'h0000 && !trimEnable
      && speedCommand > $past(speedCommand) |-> speedCommand == $past(speedCommand) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("ramp step wrong");
  property p_both;
    (seqRemote && remRunFwd && remRunRev && !active) [*8] |=> !active;
  endproperty
  a_both: assert property (p_both) else $error("forward and reverse started");
  property p_fast;
    (!fastStopN && coastStopN && fastStopMode) [*8] |-> !active;
  endproperty
  a_fast: assert property (p_fast) else $error("fast stop ignored");
endmodule
bind dss_sequencer dss_sequencer_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .seqRemote(seqRemote), .remRunFwd(remRunFwd), .remRunRev(remRunRev),
  .fastStopN(fastStopN), .coastStopN(coastStopN), .driveEnable(driveEnable), .tripActive(tripActive),
  .tripReset(tripReset), .trimEnable(trimEnable), .fastStopMode(fastStopMode), .rampupTime(rampupTime),
  .inchRampTime(inchRampTime), .speedCommand(speedCommand), .stackEnable(stackEnable), .active(active),
  .noFaultFlag(noFaultFlag)
);
`default_nettype wire

/* verif/tb_top.sv */
/*
  Self-checking bench for the start/stop sequencer.
  Assumes the operator model passes pins through and stretches stop taps.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("Error %0t: mismatch", $time); end end
module tb_top;
  import dss_pkg::*;
  // Short ms tick keeps stop timing in reach
  localparam int CM = 10;
  localparam int HC = 110 * CM;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic seqRemote = 1'b1;
  logic refRemote = 1'b1;
  logic runMode = STOP_COAST;
  logic fastMode = STOP_COAST;
  // Stop held low at start, so remote runs act only while held
  logic [NPIN-1:0] pinReq = 13'h0700;
  logic [NPIN-1:0] pins;
  logic [SPEED_W-1:0] remRef = 12'h020, keyRef = 12'h030, inchT = 12'h010;
  logic [SPEED_W-1:0] trimV = 12'h008;
  logic trimOn = 1'b0;
  logic [TIME_W-1:0] upT = 16'h0000, downT = 16'h0001, finT = 16'h0001, dlyT = 16'h0002;
  logic [SPEED_W-1:0] speedCommand;
  logic remoteDirOut, stackEnable, active, noFaultFlag;
  int err_count = 0;
  int comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  dss_operator_model #(.HOLD_CYC(HC)) u_op (.clk_sys(clk_sys), .pinReq(pinReq), .pinOut(pins));
  dss_sequencer #(.CYC_MS(CM)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .seqRemote(seqRemote), .refRemote(refRemote),
    .keyRun(pins[P_KRUN]), .keyStop(pins[P_KSTOP]), .keyInch(pins[P_KINCH]), .keyDir(pins[P_KDIR]),
    .remRunFwd(pins[P_RFWD]), .remRunRev(pins[P_RREV]), .remInch(pins[P_RINCH]),
    .remStopN(pins[P_STOPN]), .fastStopN(pins[P_FASTN]), .coastStopN(pins[P_COASTN]),
    .driveEnable(pins[P_PERMIT]), .tripActive(pins[P_TRIP]), .tripReset(pins[P_TRST]),
    .remoteReference(remRef), .keypadReference(keyRef), .inchTarget(inchT), .trimValue(trimV),
    .trimEnable(trimOn), .rampHold(1'b0), .rampupTime(upT), .rampdownTime(downT), .inchRampTime(16'h0000),
    .finalStopTime(finT), .fastStopTime(16'h0001), .stopDelay(dlyT), .runStopMode(runMode),
    .fastStopMode(fastMode), .speedCommand(speedCommand), .remoteDirOut(remoteDirOut),
    .stackEnable(stackEnable), .active(active), .noFaultFlag(noFaultFlag)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic setp(input int i, input logic v);
    tick(1);
    pinReq[i] = v;
  endtask
  task automatic final_report();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bounded wait on speed (sel 0) or on active (sel 1)
  task automatic waitSig(input logic sel, input logic [SPEED_W-1:0] v);
    int n;
    n = 0;
    while ((sel ? {11'h000, active} : speedCommand) !== v && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      $display("Error %0t: wait ran out", $time);
      final_report();
    end
  endtask
  initial begin
    tick(12);
    rst = 1'b0;
    tick(8);
    `CHK({speedCommand, stackEnable, active, noFaultFlag}, 15'h0001)
    setp(P_RREV, 1'b1);
    waitSig(1'b0, remRef);
    `CHK({remoteDirOut, stackEnable, active}, 3'h7)
    setp(P_RINCH, 1'b1);
    tick(10);
    `CHK(speedCommand, remRef)
    setp(P_RINCH, 1'b0);
    setp(P_RFWD, 1'b1);
    tick(20);
    `CHK({stackEnable, active}, 2'h0)
    pinReq[P_RFWD] = 1'b0;
    pinReq[P_RREV] = 1'b0;
    setp(P_RINCH, 1'b1);
    waitSig(1'b0, inchT);
    setp(P_RFWD, 1'b1);
    tick(10);
    `CHK(speedCommand, inchT)
    setp(P_RFWD, 1'b0);
    setp(P_RINCH, 1'b0);
    tick(10);
    `CHK(active, 1'b0)
    setp(P_RFWD, 1'b1);
    waitSig(1'b0, remRef);
    setp(P_PERMIT, 1'b0);
    tick(10);
    `CHK({stackEnable, active}, 2'h1)
    setp(P_PERMIT, 1'b1);
    setp(P_FASTN, 1'b0);
    tick(10);
    `CHK(active, 1'b0)
    setp(P_COASTN, 1'b0);
    setp(P_FASTN, 1'b1);
    tick(10);
    `CHK({stackEnable, active}, 2'h0)
    setp(P_COASTN, 1'b1);
    waitSig(1'b0, remRef);
    setp(P_TRIP, 1'b1);
    tick(10);
    `CHK({stackEnable, noFaultFlag}, 2'h0)
    setp(P_TRIP, 1'b0);
    tick(10);
    `CHK({active, noFaultFlag}, 2'h0)
    setp(P_TRST, 1'b1);
    tick(5);
    setp(P_TRST, 1'b0);
    waitSig(1'b0, remRef);
    `CHK(noFaultFlag, 1'b1)
    setp(P_RFWD, 1'b0);
    tick(8);
    `CHK({speedCommand, stackEnable}, 13'h0000)
    runMode = STOP_RAMP;
    setp(P_STOPN, 1'b1);
    tick(HC + 5);
    setp(P_RFWD, 1'b1);
    tick(5);
    setp(P_RFWD, 1'b0);
    waitSig(1'b0, remRef);
    tick(20);
    `CHK(active, 1'b1)
    setp(P_STOPN, 1'b0);
    setp(P_STOPN, 1'b1);
    waitSig(1'b0, SPEED_ZERO);
    `CHK({stackEnable, active}, 2'h3)
    waitSig(1'b1, 12'h000);
    `CHK(stackEnable, 1'b0)
    seqRemote = 1'b0;
    downT = 16'h0000;
    setp(P_KRUN, 1'b1);
    tick(5);
    setp(P_KRUN, 1'b0);
    waitSig(1'b0, remRef);
    tick(20);
    `CHK(active, 1'b1)
    refRemote = 1'b0;
    waitSig(1'b0, keyRef);
    `CHK(remoteDirOut, 1'b0)
    setp(P_KSTOP, 1'b1);
    tick(5);
    setp(P_KSTOP, 1'b0);
    waitSig(1'b0, SPEED_ZERO);
    `CHK(stackEnable, 1'b1)
    waitSig(1'b1, 12'h000);
    // Trim stays through the decel, then ramps out on its own
    downT = 16'h0001;
    trimOn = 1'b1;
    setp(P_KRUN, 1'b1);
    tick(5);
    setp(P_KRUN, 1'b0);
    waitSig(1'b0, keyRef + trimV);
    setp(P_KSTOP, 1'b1);
    tick(5);
    setp(P_KSTOP, 1'b0);
    waitSig(1'b0, trimV);
    `CHK({stackEnable, active}, 2'h3)
    waitSig(1'b0, SPEED_ZERO);
    `CHK(stackEnable, 1'b1)
    waitSig(1'b1, 12'h000);
    trimOn = 1'b0;
    fastMode = STOP_RAMP;
    setp(P_KRUN, 1'b1);
    tick(5);
    setp(P_KRUN, 1'b0);
    waitSig(1'b0, keyRef);
    setp(P_FASTN, 1'b0);
    tick(10);
    `CHK({stackEnable, active, speedCommand < keyRef}, 3'h7)
    waitSig(1'b0, SPEED_ZERO);
    waitSig(1'b1, 12'h000);
    `CHK(stackEnable, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
